/* vcb_pkg.sv */
// Constants shared by the vertical count-down and blanking block.
`default_nettype none
package vcb_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ZOOM   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Control register bit positions.
  localparam int CTRL_FORCE_SEARCH = 0;
  localparam int CTRL_OVERSCAN     = 1;
  localparam int CTRL_HBLANK       = 2;
  localparam int CTRL_FORCE_BLANK  = 3;
  // Status register field positions.
  localparam int ST_UNSETTLED = 0;
  localparam int ST_MODE_LSB  = 1;
  localparam int ST_SIXTY     = 3;
  localparam int ST_LEN_LSB   = 8;
  // Reset values.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [5:0] ZOOM_RESET = 6'h19;
  // Zoom code at which scan reaches 1.06 of nominal.
  localparam logic [5:0] ZOOM_LIMIT_CODE = 6'h1b;
  // Half-line counts: every line is two half-line ticks.
  localparam int CW = 11;
  localparam logic [CW-1:0] SEARCH_LO     = 11'h1e8; // 244 lines
  localparam logic [CW-1:0] SEARCH_LO_RGB = 11'h1b2; // 217 lines, 72 Hz
  localparam logic [CW-1:0] SEARCH_HI     = 11'h2d2; // 361 lines
  localparam logic [CW-1:0] STD50_LO      = 11'h26e; // 311 lines
  localparam logic [CW-1:0] STD50_HI      = 11'h274; // 314 lines
  localparam logic [CW-1:0] STD60_LO      = 11'h20a; // 261 lines
  localparam logic [CW-1:0] STD60_HI      = 11'h210; // 264 lines
  localparam logic [CW-1:0] NORM50        = 11'h271; // 625 half lines
  localparam logic [CW-1:0] NORM60        = 11'h20d; // 525 half lines
  localparam logic [CW-1:0] SPLIT_60      = 11'h240; // 288 lines
  localparam logic [CW-1:0] VBLANK50      = 11'h036; // 27 lines
  localparam logic [CW-1:0] VBLANK60      = 11'h02c; // 22 lines
  localparam logic [CW-1:0] OVERSCAN_MEASURE_ENABLE_EXTRA    = 11'h008; // 4 lines
  localparam logic [CW-1:0] SAND50        = 11'h01c; // 14 lines
  localparam logic [CW-1:0] SAND60        = 11'h013; // 9.5 lines
  localparam logic [CW-1:0] NORM_SLACK    = 11'h004; // 2 lines after a norm reset
  // Pulse counts for mode changes.
  localparam logic [4:0] LOCK_COUNT   = 5'h10;
  localparam logic [4:0] NORM_COUNT   = 5'h0f;
  localparam logic [2:0] MISS_NARROW  = 3'h6;
  localparam logic [2:0] MISS_SHORT   = 3'h3;
  typedef enum logic [1:0] {VCB_SEARCH, VCB_NARROW, VCB_NORM} vcb_mode_e;
endpackage
`default_nettype wire

/* vcb_vertical_countdown.sv */
// Vertical count-down divider with blanking, sandcastle and register slave.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Search window when unlocked or nonstandard length.
// - Search accepts sync lines 244 to 361.
// - Over fifteen narrow-window syncs enter narrow mode.
// - Missing sync retraces at window end.
// - Six empty periods return to search, three after a fall back from norm.
// - Fifteen norm syncs select 625/525 ratio.
// - Norm mode resets at standard count always.
// - Three misses step norm down to narrow.
// - Force-search bit holds search mode.
// - RGB insertion widens range to 72 Hz.
// - RGB vertical blank 27 or 22 lines.
// - Sandcastle vertical part 14 or 9.5 lines.
// - Horizontal drive off during whole flyback.
// - Overscan bit lengthens vertical blanking.
// - Zoom at 1.06 limits current, blanks RGB.
// - Extra blank from oscillator, not flyback.
// - Blank RGB until black loop stable.
// - Clear unsettled flag; software may force blank.
module vcb_vertical_countdown (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Timing inputs
  input  wire logic        half_line_tick,
  input  wire logic        vsync_pulse,
  input  wire logic        flyback,
  input  wire logic        hdrive_request,
  input  wire logic        hblank_window,
  input  wire logic        rgb_insert,
  input  wire logic        black_loop_stable,
  // Outputs
  output logic             vramp_start,
  output logic             vblank,
  output logic             sandcastle_v,
  output logic             hdrive,
  output logic             rgb_blank,
  output logic             zoom_current_limit,
  output logic      [1:0]  divider_mode
);
  localparam int CW = vcb_pkg::CW;

  logic [3:0]    ctrl_q;
  logic [5:0]    zoom_q;
  logic          unsettled_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] len_q;
  logic          sixty_q;
  logic [4:0]    good_q;
  logic [4:0]    norm_q;
  logic [2:0]    miss_q;
  logic          fallback_q;
  logic          seen_q;
  vcb_pkg::vcb_mode_e mode_q;
  logic          wr_ok;
  logic          force_search;

  assign force_search = ctrl_q[vcb_pkg::CTRL_FORCE_SEARCH];
  assign wr_ok        = avs_write && !avs_waitrequest;

  // Bus slave: one wait cycle, then the answer stands for one cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        vcb_pkg::REG_CTRL:   avs_readdata <= {28'h000_0000, ctrl_q};
        vcb_pkg::REG_ZOOM:   avs_readdata <= {26'h000_0000, zoom_q};
        vcb_pkg::REG_STATUS: avs_readdata <= {13'h0000, len_q, 4'h0, sixty_q, mode_q, unsettled_q};
        default:             avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= vcb_pkg::CTRL_RESET;
      zoom_q <= vcb_pkg::ZOOM_RESET;
    end else if (wr_ok && avs_byteenable[0]) begin
      if (avs_address == vcb_pkg::REG_CTRL) begin
        ctrl_q <= avs_writedata[3:0];
      end
      if (avs_address == vcb_pkg::REG_ZOOM) begin
        zoom_q <= avs_writedata[5:0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unsettled_q <= 1'b1;
    end else if (black_loop_stable) begin
      unsettled_q <= 1'b0;
    end
  end

  // Window limits chosen from the detected field standard; the search floor from rgb_insert.
  logic [CW-1:0] search_lo;
  logic [CW-1:0] std_lo;
  logic [CW-1:0] std_hi;
  logic [CW-1:0] norm_len;
  logic [CW-1:0] vblank_len;
  logic [CW-1:0] sand_len;
  logic          in_search;
  logic          in_std;
  logic          at_norm;
  logic          sync_search;
  logic          sync_std;
  logic          field_end;

  always_comb begin
    std_lo     = sixty_q ? vcb_pkg::STD60_LO : vcb_pkg::STD50_LO;
    std_hi     = sixty_q ? vcb_pkg::STD60_HI : vcb_pkg::STD50_HI;
    norm_len   = sixty_q ? vcb_pkg::NORM60 : vcb_pkg::NORM50;
    vblank_len = sixty_q ? vcb_pkg::VBLANK60 : vcb_pkg::VBLANK50;
    if (ctrl_q[vcb_pkg::CTRL_OVERSCAN]) begin
      vblank_len = vblank_len + vcb_pkg::OVERSCAN_MEASURE_ENABLE_EXTRA;
    end
    sand_len   = sixty_q ? vcb_pkg::SAND60 : vcb_pkg::SAND50;
    search_lo  = rgb_insert ? vcb_pkg::SEARCH_LO_RGB : vcb_pkg::SEARCH_LO;
  end

  assign in_search   = (cnt_q >= search_lo) && (cnt_q <= vcb_pkg::SEARCH_HI);
  assign in_std      = (cnt_q >= std_lo) && (cnt_q <= std_hi);
  assign at_norm     = (cnt_q == norm_len) || (cnt_q == norm_len - 11'h001);
  assign sync_search = vsync_pulse && in_search;
  assign sync_std    = vsync_pulse && in_std;

  always_comb begin
    case (mode_q)
      vcb_pkg::VCB_SEARCH: begin
        field_end = sync_search || (half_line_tick && cnt_q >= vcb_pkg::SEARCH_HI);
      end
      vcb_pkg::VCB_NARROW: begin
        field_end = sync_std || (half_line_tick && cnt_q >= std_hi);
      end
      vcb_pkg::VCB_NORM: begin
        field_end = half_line_tick && cnt_q >= norm_len - 11'h001;
      end
      default: begin
        field_end = 1'b1;
      end
    endcase
  end

  // Half-line counter since the last retrace.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (field_end) begin
      cnt_q <= '0;
    end else if (half_line_tick) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // Measured field length and standard detection.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q   <= '0;
      sixty_q <= 1'b0;
    end else if (sync_search && mode_q != vcb_pkg::VCB_NORM) begin
      len_q   <= cnt_q;
      sixty_q <= cnt_q < vcb_pkg::SPLIT_60;
    end
  end

  // Sync seen inside the standard window during a norm-mode field.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else if (field_end) begin
      seen_q <= 1'b0;
    end else if (sync_std || (vsync_pulse && cnt_q < vcb_pkg::NORM_SLACK)) begin
      // A norm reset lands just before the sync, so an early sync also counts.
      seen_q <= 1'b1;
    end
  end

  // Mode state machine.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q     <= vcb_pkg::VCB_SEARCH;
      good_q     <= '0;
      norm_q     <= '0;
      miss_q     <= '0;
      fallback_q <= 1'b0;
    end else if (force_search) begin
      mode_q     <= vcb_pkg::VCB_SEARCH;
      good_q     <= '0;
      norm_q     <= '0;
      miss_q     <= '0;
      fallback_q <= 1'b0;
    end else begin
      case (mode_q)
        vcb_pkg::VCB_SEARCH: begin
          if (sync_std) begin
            if (good_q + 5'h01 >= vcb_pkg::LOCK_COUNT) begin
              mode_q <= vcb_pkg::VCB_NARROW;
              good_q <= '0;
              norm_q <= '0;
              miss_q <= '0;
              fallback_q <= 1'b0;
            end else begin
              good_q <= good_q + 5'h01;
            end
          end else if (field_end) begin
            good_q <= '0;
          end
        end
        vcb_pkg::VCB_NARROW: begin
          if (sync_std) begin
            miss_q <= '0;
            if (at_norm) begin
              if (norm_q + 5'h01 >= vcb_pkg::NORM_COUNT) begin
                mode_q     <= vcb_pkg::VCB_NORM;
                norm_q     <= '0;
                fallback_q <= 1'b0;
              end else begin
                norm_q <= norm_q + 5'h01;
              end
            end else begin
              norm_q <= '0;
            end
          end else if (field_end) begin
            norm_q <= '0;
            if (miss_q + 3'h1 >= (fallback_q ? vcb_pkg::MISS_SHORT : vcb_pkg::MISS_NARROW)) begin
              mode_q     <= vcb_pkg::VCB_SEARCH;
              miss_q     <= '0;
              good_q     <= '0;
              fallback_q <= 1'b0;
            end else begin
              miss_q <= miss_q + 3'h1;
            end
          end
        end
        vcb_pkg::VCB_NORM: begin
          if (field_end) begin
            if (seen_q || sync_std) begin
              miss_q <= '0;
            end else if (miss_q + 3'h1 >= vcb_pkg::MISS_SHORT) begin
              mode_q     <= vcb_pkg::VCB_NARROW;
              miss_q     <= '0;
              fallback_q <= 1'b1;
            end else begin
              miss_q <= miss_q + 3'h1;
            end
          end
        end
        default: begin
          mode_q <= vcb_pkg::VCB_SEARCH;
        end
      endcase
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vramp_start        <= 1'b0;
      vblank             <= 1'b1;
      sandcastle_v       <= 1'b1;
      hdrive             <= 1'b0;
      rgb_blank          <= 1'b1;
      zoom_current_limit <= 1'b0;
      divider_mode       <= 2'h0;
    end else begin
      vramp_start  <= field_end;
      vblank       <= cnt_q < vblank_len;
      sandcastle_v <= cnt_q < sand_len;
      hdrive       <= hdrive_request && !flyback;
      zoom_current_limit <= zoom_q >= vcb_pkg::ZOOM_LIMIT_CODE;
      divider_mode <= mode_q;
      rgb_blank <= (cnt_q < vblank_len) || unsettled_q
                   || ctrl_q[vcb_pkg::CTRL_FORCE_BLANK] || (zoom_q >= vcb_pkg::ZOOM_LIMIT_CODE)
                   || (ctrl_q[vcb_pkg::CTRL_HBLANK] && hblank_window);
    end
  end
endmodule
`default_nettype wire

/* vcb_vertical_countdown_monitor.sv */
// Port assertions for the vertical count-down block.
`timescale 1ns/1ps
`default_nettype none
module vcb_vcd_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Timing
  input wire logic       half_line_tick,
  input wire logic       flyback,
  input wire logic       vramp_start,
  input wire logic       vblank,
  input wire logic       sandcastle_v,
  input wire logic       hdrive,
  input wire logic       rgb_blank,
  input wire logic       zoom_current_limit,
  input wire logic [1:0] divider_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [10:0] tcnt_q;
  logic        nrm_q;
  // Counts half lines since the last retrace and notes its mode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcnt_q <= 11'h000;
      nrm_q  <= 1'b0;
    end else if (vramp_start) begin
      tcnt_q <= 11'h000;
      nrm_q  <= divider_mode == 2'h2;
    end else if (half_line_tick) begin
      tcnt_q <= tcnt_q + 11'h001;
    end
  end
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_retrace_blank;
    !vramp_start && vblank ##1 vblank && sandcastle_v;
  endsequence
  a_bus_one_wait: assert property (s_req_wait |=> !avs_waitrequest) else $error("bus answer late");
  a_drive_flyback: assert property ($past(flyback) |-> !hdrive) else $error("drive in flyback");
  a_zoom_blank: assert property (zoom_current_limit [*2] |-> rgb_blank) else $error("zoom not blanked");
  a_vblank_rgb: assert property (vblank [*2] |-> rgb_blank) else $error("vblank not on rgb");
  a_sand_in_blank: assert property (sandcastle_v |-> vblank) else $error("sandcastle past blank");
  a_retrace_pulse: assert property (vramp_start |=> s_retrace_blank) else $error("retrace pulse bad");
  a_norm_period: assert property (vramp_start && nrm_q && divider_mode == 2'h2
    |-> tcnt_q inside {[11'd623:11'd626], [11'd523:11'd526]}) else $error("norm period wrong");
  a_search_exit: assert property ($past(divider_mode) == 2'h0 && divider_mode != 2'h0
    |-> divider_mode == 2'h1) else $error("search exit wrong");
endmodule
bind vcb_vertical_countdown vcb_vcd_monitor u_mon (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .half_line_tick, .flyback, .vramp_start, .vblank, .sandcastle_v, .hdrive, .rgb_blank, .zoom_current_limit,
  .divider_mode);
`default_nettype wire

/* vcb_sync_source.sv */
// Sync separator model giving half-line ticks and field syncs.
`timescale 1ns/1ps
`default_nettype none
module vcb_sync_source (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Field control
  input  wire logic        sync_en,
  input  wire logic [10:0] field_len,
  // Sync outputs
  output logic             half_line_tick,
  output logic             vsync_pulse
);
  logic [10:0] cnt_q;
  // No guard pulse is driven, so none can overlap the measuring lines.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_line_tick <= 1'b0;
    end else begin
      half_line_tick <= ~half_line_tick;
    end
  end
  // Emits one sync after each field length of half lines.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q       <= 11'h000;
      vsync_pulse <= 1'b0;
    end else begin
      vsync_pulse <= 1'b0;
      if (half_line_tick && cnt_q == field_len - 11'h001) begin
        cnt_q       <= 11'h000;
        vsync_pulse <= sync_en;
      end else if (half_line_tick) begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

/* vcb_vertical_countdown_bench.sv */
// Self-checking bench for the vertical count-down block.
`timescale 1ns/1ps
`default_nettype none
module vcb_vertical_countdown_bench;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, half_line_tick, vsync_pulse, sync_en;
  logic        flyback, hdrive_request, hblank_window, rgb_insert, black_loop_stable, vramp_start;
  logic        vblank, sandcastle_v, hdrive, rgb_blank, zoom_current_limit, hw;
  logic [1:0]  divider_mode;
  logic [3:0]  avs_address, avs_byteenable;
  logic [10:0] field_len;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          err_total, comparisons, seed, vb, sc;
  vcb_vertical_countdown DUT (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .half_line_tick, .vsync_pulse, .flyback,
    .hdrive_request, .hblank_window, .rgb_insert, .black_loop_stable, .vramp_start, .vblank,
    .sandcastle_v, .hdrive, .rgb_blank, .zoom_current_limit, .divider_mode);
  vcb_sync_source u_src (.clk, .sys_rst, .sync_en, .field_len, .half_line_tick, .vsync_pulse);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    flyback        <= 1'($random(seed));
    hdrive_request <= 1'($random(seed));
    hblank_window  <= 1'($random(seed));
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    chk((got >= exp - 2 && got <= exp + 2) ? exp : got, exp);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk(n < 40, 1'b1);
  endtask
  function automatic int exp_vb(bit sixty, bit overscan_measure_enable);
    return (sixty ? 2 * 22 : 2 * 27) + (overscan_measure_enable ? 2 * 4 : 0);
  endfunction
  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (divider_mode !== m && n < 45000) begin
      @(posedge clk);
      n++;
    end
    chk(divider_mode, m);
  endtask
  task automatic measure;
    int n;
    n = 0;
    vb = 0;
    sc = 0;
    while (vramp_start !== 1'b1 && n < 1500) begin
      @(posedge clk);
      n++;
    end
    repeat (300) begin
      @(posedge clk);
      vb += int'(half_line_tick && vblank);
      sc += int'(half_line_tick && sandcastle_v);
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    {seed, err_total, comparisons} = {32'd5942, 64'd0};
    {sys_rst, sync_en, avs_read, avs_write, rgb_insert, black_loop_stable} = 6'b110000;
    {flyback, hdrive_request, hblank_window, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    field_len = 11'd625;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk(rgb_blank, 1'b1);
    bus(1'b0, vcb_pkg::REG_ZOOM, 32'h0);
    chk(rd, 32'h0000_0019);
    bus(1'b0, vcb_pkg::REG_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    vb = $random(seed) & 32'h0000_000f;
    bus(1'b1, vcb_pkg::REG_CTRL, vb);
    bus(1'b0, vcb_pkg::REG_CTRL, 32'h0);
    chk(rd[3:0], vb[3:0]);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0);
    bus(1'b1, vcb_pkg::REG_ZOOM, 32'h0000_001b);
    repeat (3) @(posedge clk);
    chk(zoom_current_limit, 1'b1);
    bus(1'b1, vcb_pkg::REG_ZOOM, 32'h0000_001a);
    repeat (3) @(posedge clk);
    chk(zoom_current_limit, 1'b0);
    bus(1'b1, vcb_pkg::REG_ZOOM, 32'h0000_0019);
    black_loop_stable <= 1'b1;
    bus(1'b0, vcb_pkg::REG_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    wait_mode(2'h1);
    wait_mode(2'h2);
    bus(1'b0, vcb_pkg::REG_STATUS, 32'h0);
    chk(rd[3:1], 3'h2);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0000_0002);
    measure();
    near(vb, exp_vb(1'b0, 1'b1));
    near(sc, 2 * 14);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0);
    measure();
    near(vb, exp_vb(1'b0, 1'b0));
    chk(rgb_blank, 1'b0);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0000_0004);
    @(posedge clk);
    hw = hblank_window;
    repeat (40) begin
      @(posedge clk);
      chk(rgb_blank, hw);
      hw = hblank_window;
    end
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0000_0008);
    repeat (3) @(posedge clk);
    chk(rgb_blank, 1'b1);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0);
    sync_en <= 1'b0;
    wait_mode(2'h1);
    wait_mode(2'h0);
    sync_en    <= 1'b1;
    field_len  <= 11'd525;
    rgb_insert <= 1'b1;
    wait_mode(2'h1);
    bus(1'b0, vcb_pkg::REG_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    measure();
    near(vb, exp_vb(1'b1, 1'b0));
    near(sc, 19);
    bus(1'b1, vcb_pkg::REG_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk);
    chk(divider_mode, 2'h0);
    results();
  end
endmodule
`default_nettype wire
